// [sbl_map.svh]
`ifndef SBL_MAP_SVH
`define SBL_MAP_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define SBL_OFS_STRAP 8'h00
`define SBL_OFS_PIN_OUT 8'h04
`define SBL_OFS_PIN_OE 8'h08
`define SBL_OFS_PIN_IN 8'h0C
`define SBL_OFS_PULL 8'h10

// ----------------------------------------------------------------
// Strap status field positions
// ----------------------------------------------------------------
`define SBL_FLD_STRAP_LO 0
`define SBL_FLD_STRAP_HI 2
`define SBL_FLD_VALID 3
`define SBL_FLD_BOOT_LO 4
`define SBL_FLD_BOOT_HI 6
`define SBL_FLD_PRINT 7
`define SBL_FLD_BADCOMBO 8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SBL_RST_STRAP 3'h4
`define SBL_RST_PIN_OUT 3'h0
`define SBL_RST_PIN_OE 3'h0
`define SBL_RST_PULL 3'h4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SBL_CLK_NS 10
`define SBL_SETTLE_NS 50
`define SBL_SETTLE_CYC \
    ((`SBL_SETTLE_NS + `SBL_CLK_NS - 1) / `SBL_CLK_NS)

`endif

// [sbl_pin_model.sv]
// ----------------------------------------------------------------
// Pull resistors and host outputs on the strap pins
// ----------------------------------------------------------------
module sbl_pin_model (
    // Clock
    input wire logic clock,
    // Host side
    input wire sbl_pkg::sbl_strap_t want,
    input wire sbl_pkg::sbl_strap_t host_en,
    // Device side
    input wire sbl_pkg::sbl_strap_t dut_out,
    input wire sbl_pkg::sbl_strap_t dut_oe_n,
    input wire sbl_pkg::sbl_strap_t dut_pull,
    output sbl_pkg::sbl_strap_t pin
);
    timeunit 1ns;
    timeprecision 1ns;
    import sbl_pkg::*;

    logic [2:0] wander_q = 3'h5;

    // Unpulled floating pins wander, so no stale level is trusted
    always_ff @(posedge clock) begin
        wander_q <= ~wander_q;
    end

    // Device drive wins, then host drive, then pull-up
    always_comb begin
        for (int b = 0; b < 3; b++) begin
            if (!dut_oe_n[b])
                pin[b] = dut_out[b];
            else if (host_en[b])
                pin[b] = want[b];
            else if (dut_pull[b])
                pin[b] = 1'b1;
            else
                pin[b] = wander_q[b];
        end
    end
endmodule

// [sbl_pkg.sv]
package sbl_pkg;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------

    // Three strap pins travel together, third in the top bit
    typedef struct packed {
        logic strap_pin_third;
        logic strap_pin_second;
        logic strap_pin_first;
    } sbl_strap_t;

    // Decoded boot mode, one-hot
    typedef enum logic [2:0] {
        SBL_BOOT_FLASH    = 3'h1,
        SBL_BOOT_DOWNLOAD = 3'h2,
        SBL_BOOT_INVALID  = 3'h4
    } sbl_boot_t;

    // Capture sequence, one-hot
    typedef enum logic [2:0] {
        SBL_ST_OFF    = 3'h1,
        SBL_ST_SETTLE = 3'h2,
        SBL_ST_HELD   = 3'h4
    } sbl_state_t;

endpackage

// [sbl_strap_latch.sv]
// Chosen here: the register addresses and the Wishbone register port.

`include "sbl_map.svh"

module sbl_strap_latch (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Chip enable pin and static print control
    input wire logic chip_en,
    input wire logic [1:0] print_ctl,
    // Strap pins, four signals each
    input wire sbl_pkg::sbl_strap_t strap_pin_in,
    output sbl_pkg::sbl_strap_t strap_pin_out,
    output sbl_pkg::sbl_strap_t strap_pin_oe_n,
    output sbl_pkg::sbl_strap_t strap_pin_pull_up,
    // Decoded results
    output sbl_pkg::sbl_boot_t boot_mode,
    output logic print_en,
    output logic strap_valid
);
    import sbl_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    localparam logic [3:0] SETTLE_LAST = 4'(`SBL_SETTLE_CYC - 1);

    logic [3:0] raw_in;
    logic [3:0] clean_in;
    sbl_strap_t pins_s;
    logic en_s;

    sbl_state_t state_q;
    sbl_state_t state_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    sbl_strap_t prev_q;
    sbl_strap_t latch_q;
    sbl_strap_t latch_d;
    logic valid_q;
    logic valid_d;

    sbl_boot_t boot_d;
    sbl_boot_t boot_q;
    logic print_d;
    logic print_q;
    logic bad_combo;

    logic [2:0] pin_out_q;
    logic [2:0] pin_oe_q;
    logic [2:0] pull_q;
    sbl_strap_t out_q;
    sbl_strap_t oe_n_q;
    sbl_strap_t pu_q;
    sbl_strap_t out_d;
    sbl_strap_t oe_n_d;
    sbl_strap_t pu_d;

    logic ack_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic req;
    logic wr_go;
    logic hit_strap;
    logic hit_out;
    logic hit_oe;
    logic hit_in;
    logic hit_pull;
    logic capturing;
    logic pins_steady;
    logic settle_done;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------

    // Pins and chip enable come from outside the clock domain
    assign raw_in = {chip_en, strap_pin_in};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            sbl_sync3 #(
                .RST_VAL(gi == 2 ? 1'b1 : 1'b0)
            ) u_sync (
                .clock(clock),
                .rst(rst),
                .din(raw_in[gi]),
                .dout(clean_in[gi])
            );
        end
    endgenerate

    assign pins_s = clean_in[2:0];
    assign en_s = clean_in[3];

    // ----------------------------------------------------------------
    // Capture sequence
    // ----------------------------------------------------------------

    // Levels must sit still for a few cycles so a bouncing pull-up
    // edge is not taken as the strap value
    assign pins_steady = (pins_s == prev_q);
    assign settle_done = pins_steady && (cnt_q == SETTLE_LAST);
    assign capturing = (state_q != SBL_ST_HELD);

    // Next state, counter and latch contents
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        latch_d = latch_q;
        valid_d = valid_q;
        case (state_q)
            SBL_ST_OFF: begin
                // Power off forgets the straps
                latch_d = `SBL_RST_STRAP;
                valid_d = 1'b0;
                cnt_d = 4'h0;
                if (en_s) begin
                    state_d = SBL_ST_SETTLE;
                end
            end
            SBL_ST_SETTLE: begin
                if (!en_s) begin
                    state_d = SBL_ST_OFF;
                end else if (!pins_steady) begin
                    cnt_d = 4'h0;
                end else if (settle_done) begin
                    latch_d = pins_s;
                    valid_d = 1'b1;
                    state_d = SBL_ST_HELD;
                end else begin
                    cnt_d = cnt_q + 4'h1;
                end
            end
            SBL_ST_HELD: begin
                // Pin activity no longer reaches the latches
                if (!en_s) begin
                    state_d = SBL_ST_OFF;
                end
            end
            default: begin
                state_d = SBL_ST_OFF;
            end
        endcase
    end

    // Sequence registers; a system reset reopens the window
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= SBL_ST_SETTLE;
            cnt_q <= 4'h0;
            prev_q <= `SBL_RST_STRAP;
            latch_q <= `SBL_RST_STRAP;
            valid_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            prev_q <= pins_s;
            latch_q <= latch_d;
            valid_q <= valid_d;
        end
    end

    // ----------------------------------------------------------------
    // Boot mode and print decode
    // ----------------------------------------------------------------

    // Second and third both low is illegal from outside
    assign bad_combo = !latch_q.strap_pin_second &&
        !latch_q.strap_pin_third;

    // Boot mode from the held straps
    always_comb begin
        if (latch_q.strap_pin_first && latch_q.strap_pin_third) begin
            boot_d = SBL_BOOT_FLASH;
        end else if (latch_q.strap_pin_first &&
                     latch_q.strap_pin_second) begin
            boot_d = SBL_BOOT_DOWNLOAD;
        end else begin
            boot_d = SBL_BOOT_INVALID;
        end
    end

    // Print enable from static control and second strap
    always_comb begin
        case (print_ctl)
            2'h0: print_d = 1'b1;
            2'h1: print_d = !latch_q.strap_pin_second;
            2'h2: print_d = latch_q.strap_pin_second;
            2'h3: print_d = 1'b0;
            default: print_d = 1'b0;
        endcase
    end

    // Registered so outputs come from flops; one cycle behind decode
    always_ff @(posedge clock) begin
        if (rst) begin
            boot_q <= SBL_BOOT_INVALID;
            print_q <= 1'b0;
        end else begin
            boot_q <= valid_q ? boot_d : SBL_BOOT_INVALID;
            print_q <= valid_q && print_d;
        end
    end

    assign boot_mode = boot_q;
    assign print_en = print_q;
    assign strap_valid = valid_q;

    // ----------------------------------------------------------------
    // Pin drive
    // ----------------------------------------------------------------

    // While capturing the pins float with the third pulled up;
    // afterwards software owns drive and pulls
    assign out_d = capturing ? `SBL_RST_PIN_OUT : pin_out_q;
    assign oe_n_d = capturing ? 3'h7 : ~pin_oe_q;
    assign pu_d = capturing ? `SBL_RST_PULL : pull_q;

    // Pin output flops
    always_ff @(posedge clock) begin
        if (rst) begin
            out_q <= `SBL_RST_PIN_OUT;
            oe_n_q <= 3'h7;
            pu_q <= `SBL_RST_PULL;
        end else begin
            out_q <= out_d;
            oe_n_q <= oe_n_d;
            pu_q <= pu_d;
        end
    end

    assign strap_pin_out = out_q;
    assign strap_pin_oe_n = oe_n_q;
    assign strap_pin_pull_up = pu_q;

    // ----------------------------------------------------------------
    // Wishbone slave
    // ----------------------------------------------------------------

    // Address decode; unmapped words read zero and still ack
    assign req = wb_cyc_i && wb_stb_i;
    assign wr_go = req && wb_we_i && ack_q && wb_sel_i[0];
    assign hit_strap = (wb_adr_i == `SBL_OFS_STRAP);
    assign hit_out = (wb_adr_i == `SBL_OFS_PIN_OUT);
    assign hit_oe = (wb_adr_i == `SBL_OFS_PIN_OE);
    assign hit_in = (wb_adr_i == `SBL_OFS_PIN_IN);
    assign hit_pull = (wb_adr_i == `SBL_OFS_PULL);

    // Read mux
    always_comb begin
        rdata_d = 32'h0;
        if (hit_strap) begin
            rdata_d[`SBL_FLD_STRAP_HI:`SBL_FLD_STRAP_LO] = latch_q;
            rdata_d[`SBL_FLD_VALID] = valid_q;
            rdata_d[`SBL_FLD_BOOT_HI:`SBL_FLD_BOOT_LO] = boot_q;
            rdata_d[`SBL_FLD_PRINT] = print_q;
            rdata_d[`SBL_FLD_BADCOMBO] = valid_q && bad_combo;
        end else if (hit_out) begin
            rdata_d[2:0] = pin_out_q;
        end else if (hit_oe) begin
            rdata_d[2:0] = pin_oe_q;
        end else if (hit_in) begin
            rdata_d[2:0] = pins_s;
        end else if (hit_pull) begin
            rdata_d[2:0] = pull_q;
        end
    end

    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clock) begin
        if (rst) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0;
        end else begin
            ack_q <= req && !ack_q;
            rdata_q <= (req && !ack_q) ? rdata_d : 32'h0;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;

    // Software pin registers; write lands on the ack edge
    always_ff @(posedge clock) begin
        if (rst) begin
            pin_out_q <= `SBL_RST_PIN_OUT;
            pin_oe_q <= `SBL_RST_PIN_OE;
            pull_q <= `SBL_RST_PULL;
        end else if (wr_go) begin
            if (hit_out) begin
                pin_out_q <= wb_dat_i[2:0];
            end
            if (hit_oe) begin
                pin_oe_q <= wb_dat_i[2:0];
            end
            if (hit_pull) begin
                pull_q <= wb_dat_i[2:0];
            end
        end
    end

endmodule

// [sbl_strap_latch_asserts.sv]
// ----------------------------------------------------------------
// Strap latch checker
// ----------------------------------------------------------------
module sbl_strap_latch_chk (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    // Pins and results
    input wire logic chip_en,
    input wire logic [1:0] print_ctl,
    input wire sbl_pkg::sbl_strap_t strap_pin_in,
    input wire sbl_pkg::sbl_strap_t strap_pin_oe_n,
    input wire sbl_pkg::sbl_strap_t strap_pin_pull_up,
    input wire sbl_pkg::sbl_boot_t boot_mode,
    input wire logic print_en,
    input wire logic strap_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    import sbl_pkg::*;
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);

    sbl_strap_t cap_q;

    // Shadow pins until held; pins are steady then, so it equals the latch
    always_ff @(posedge clock) begin
        if (!strap_valid)
            cap_q <= strap_pin_in;
    end

    function automatic sbl_boot_t boot_of(sbl_strap_t s);
        if (s.strap_pin_first && s.strap_pin_third)
            return SBL_BOOT_FLASH;
        if (s.strap_pin_first && s.strap_pin_second)
            return SBL_BOOT_DOWNLOAD;
        return SBL_BOOT_INVALID;
    endfunction

    function automatic logic print_of(logic [1:0] c, logic sec);
        return (c == 2'h0) | ((c == 2'h1) & !sec) | ((c == 2'h2) & sec);
    endfunction

    a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_next_cycle: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_dat_quiet_idle: assert property (
        !wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_reset_state_clean: assert property ($fell(rst) |->
        !strap_valid && !print_en && boot_mode == SBL_BOOT_INVALID &&
        strap_pin_pull_up == 3'h4 && strap_pin_oe_n == 3'h7)
        else $error("bad state after reset");
    a_pins_float_capture: assert property (
        !strap_valid && !$past(strap_valid) |-> strap_pin_oe_n == 3'h7)
        else $error("pin driven while capturing");
    a_power_off_clears: assert property (
        !chip_en [*7] |-> !strap_valid)
        else $error("straps kept while powered off");
    a_held_boot_stable: assert property (
        strap_valid [*3] |-> $stable(boot_mode))
        else $error("boot mode moved while held");
    a_boot_mode_decode: assert property (
        strap_valid [*2] |-> boot_mode == boot_of(cap_q))
        else $error("boot mode decode wrong");
    a_print_en_decode: assert property (strap_valid [*2] |->
        print_en == print_of($past(print_ctl), cap_q.strap_pin_second))
        else $error("print enable decode wrong");
endmodule

bind sbl_strap_latch sbl_strap_latch_chk u_chk (
    .clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .chip_en(chip_en),
    .print_ctl(print_ctl), .strap_pin_in(strap_pin_in),
    .strap_pin_oe_n(strap_pin_oe_n), .strap_pin_pull_up(strap_pin_pull_up),
    .boot_mode(boot_mode), .print_en(print_en), .strap_valid(strap_valid));

// [sbl_strap_latch_tb_top.sv]
`include "sbl_map.svh"

module sbl_strap_latch_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import sbl_pkg::*;

    logic clock, rst, cyc, stb, we, chip_en, ack, print_en, strap_valid;
    logic [7:0] adr;
    logic [1:0] print_ctl;
    logic [31:0] dati, dato, rd;
    sbl_strap_t want, host_en, pin, pout, poe_n, ppu;
    sbl_boot_t boot_mode;
    int fail_count, checked, i, c;

    sbl_strap_latch u_dut (
        .clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dati),
        .wb_dat_o(dato), .wb_ack_o(ack), .chip_en(chip_en),
        .print_ctl(print_ctl), .strap_pin_in(pin), .strap_pin_out(pout),
        .strap_pin_oe_n(poe_n), .strap_pin_pull_up(ppu),
        .boot_mode(boot_mode), .print_en(print_en),
        .strap_valid(strap_valid));

    sbl_pin_model u_pins (
        .clock(clock), .want(want), .host_en(host_en), .dut_out(pout),
        .dut_oe_n(poe_n), .dut_pull(ppu), .pin(pin));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [2:0] boot_of(sbl_strap_t s);
        if (s.strap_pin_first && s.strap_pin_third)
            return SBL_BOOT_FLASH;
        if (s.strap_pin_first && s.strap_pin_second)
            return SBL_BOOT_DOWNLOAD;
        return SBL_BOOT_INVALID;
    endfunction

    function automatic logic print_of(logic [1:0] k, logic sec);
        return (k == 2'h0) | ((k == 2'h1) & !sec) | ((k == 2'h2) & sec);
    endfunction

    task automatic report_and_stop();
        $display("checks %0d failures %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
        end
    endtask

    // One classic cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dati <= d;
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) begin
            fail_count++;
            report_and_stop();
        end
        rd = dato;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clock);
    endtask

    task automatic wait_valid();
        int n;
        n = 0;
        while (strap_valid !== 1'b1 && n < 100) begin
            @(posedge clock);
            n++;
        end
        if (strap_valid !== 1'b1) begin
            fail_count++;
            report_and_stop();
        end
        repeat (2) @(posedge clock);
    endtask

    // Read back the held straps, then sweep every print setting
    task automatic verify(input sbl_strap_t s);
        wb(1'b0, `SBL_OFS_STRAP, 32'h0);
        check(rd, {24'h0, print_of(print_ctl, s[1]), boot_of(s),
                   1'b1, s});
        check(boot_mode, boot_of(s));
        for (c = 0; c < 4; c++) begin
            print_ctl <= c[1:0];
            repeat (3) @(posedge clock);
            check(print_en, print_of(c[1:0], s[1]));
        end
    endtask

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial begin
        rst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        dati = 32'h0;
        chip_en = 1'b1;
        print_ctl = 2'h0;
        want = 3'h7;
        host_en = 3'h7;
        fail_count = 0;
        checked = 0;
        repeat (20) @(posedge clock);
        // Second and third never both low at reset
        for (i = 2; i < 9; i++) begin
            want <= (i == 8) ? 3'h1 : i[2:0];
            host_en <= (i == 8) ? 3'h3 : 3'h7;
            rst <= 1'b1;
            repeat (4) @(posedge clock);
            rst <= 1'b0;
            wait_valid();
            verify((i == 8) ? 3'h5 : i[2:0]);
        end
        host_en <= 3'h7;
        want <= 3'h2;
        repeat (8) @(posedge clock);
        wb(1'b0, `SBL_OFS_STRAP, 32'h0);
        check(rd[2:0], 3'h5);
        check(boot_mode, SBL_BOOT_FLASH);
        wb(1'b0, `SBL_OFS_PIN_IN, 32'h0);
        check(rd, 32'h2);
        wb(1'b1, `SBL_OFS_STRAP, 32'h0);
        wb(1'b1, `SBL_OFS_PIN_OUT, 32'h5);
        wb(1'b1, `SBL_OFS_PIN_OE, 32'h7);
        repeat (6) @(posedge clock);
        wb(1'b0, `SBL_OFS_PIN_IN, 32'h0);
        check(rd, 32'h5);
        wb(1'b0, `SBL_OFS_PIN_OE, 32'h0);
        check(rd, 32'h7);
        wb(1'b0, `SBL_OFS_PULL, 32'h0);
        check(rd, 32'h4);
        check(ppu, 3'h4);
        wb(1'b0, `SBL_OFS_STRAP, 32'h0);
        check(rd[2:0], 3'h5);
        wb(1'b0, 8'h20, 32'h0);
        check(rd, 32'h0);
        wb(1'b1, `SBL_OFS_PIN_OE, 32'h0);
        chip_en <= 1'b0;
        repeat (10) @(posedge clock);
        check(strap_valid, 1'b0);
        chip_en <= 1'b1;
        wait_valid();
        verify(3'h2);
        report_and_stop();
    end
endmodule

// [sbl_sync3.sv]
// Three-stage pin synchroniser; output moves once stages two and
// three agree, so a single-cycle glitch past stage one is dropped.
module sbl_sync3 #(
    parameter logic RST_VAL = 1'b0
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Pin level and its clean copy
    input wire logic din,
    output logic dout
);

    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic out_q;
    logic agree;

    // Only stage two reads stage one
    assign agree = (s2_q == s3_q);
    assign dout = out_q;

    // Shift chain and qualified output
    always_ff @(posedge clock) begin
        if (rst) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            out_q <= RST_VAL;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (agree) begin
                out_q <= s3_q;
            end
        end
    end

endmodule
